// ==== verilog/led_mux_consts.svh ====
/*
 * Constants for the LED multiplex serial front end: word layout, scan and
 * timing counts. Assumes a 20 MHz system clock on both ends.
 */
// Function
// - shift input bit on serial clock rise
// - select low to transfer, else ignore
// - select rise latches last sixteen bits
// - upper byte address, lower byte data
// - host sends bit fifteen first
// - accept either serial clock idle level
// - unlit drive pins left undriven
// - external multiplex clock between 1 and 8 MHz
// - scan up to eight digits, eight segments
// - five-digit variant lights only five digits
// - pin k sinks digit k cathode
// - other pins carry dp..b, ninth pin a
// - segment wiring differs per scanned digit
// - serial interface is write only
`ifndef LED_MUX_CONSTS_SVH
`define LED_MUX_CONSTS_SVH
`define WORD_BITS       16
`define ADDR_MSB        15
`define ADDR_LSB        8
`define DATA_MSB        7
`define DATA_LSB        0
`define NUM_DIGITS      8
`define DRIVE_PINS      9
`define SCAN_LIMIT_ADDR 8'h03
`define DIGIT_ADDR_BASE 8'h60
`define DIGIT_ADDR_P0   8'h20
`define DIGIT_ADDR_P1   8'h40
`define DIGIT_ADDR_MASK 8'hf8
`define SCAN_LIMIT_RST  3'h4
`define SYS_CLK_HZ      20000000
`define SLOT_MUX_TICKS  16'h0100
`define SCLK_HALF_NS    200
`define SYS_PERIOD_NS   50
`define SCLK_HALF_CYC   ((`SCLK_HALF_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`endif

// ==== verilog/led_mux_pkg.sv ====
/*
 * Types for the LED multiplex serial front end.
 * Assumes led_mux_consts.svh is reachable on the include path.
 */
`default_nettype none
`include "led_mux_consts.svh"
package led_mux_pkg;
  typedef logic [`WORD_BITS-1:0]  word_t;
  typedef logic [7:0]             byte_t;
  typedef logic [`DRIVE_PINS-1:0] pins_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_LOW, HOST_HIGH, HOST_DONE} host_state_t;
endpackage
`default_nettype wire

// ==== verilog/led_mux_if.sv ====
/*
 * Interface joining the host end and the driver end: three write-only
 * serial wires. Assumes both ends run from their own system clocks.
 */
`timescale 1ns/100ps
`default_nettype none
interface led_mux_if;
  logic sclk;
  logic sel_n;
  logic sdata;
  modport host   (output sclk, output sel_n, output sdata);
  modport device (input sclk, input sel_n, input sdata);
endinterface
`default_nettype wire

// ==== verilog/led_mux_host.sv ====
/*
 * Host end: shifts one 16-bit command word out per request.
 * Assumes one clock (clock, 20 MHz); serial clock derived by a divider.
 */
`timescale 1ns/100ps
`default_nettype none
module led_mux_host
  import led_mux_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  led_mux_if.host                link,
  input  wire logic              req_valid,
  input  wire led_mux_pkg::byte_t req_addr,
  input  wire led_mux_pkg::byte_t req_data,
  output var  logic              req_ready
);
  import led_mux_pkg::*;

  host_state_t state_q;
  word_t       shift_q;
  logic [4:0]  bits_q;
  logic [3:0]  div_q;
  logic        tick;
  logic        sclk_q;
  logic        sel_n_q;

  assign tick = (div_q == 4'(`SCLK_HALF_CYC - 1));
  assign link.sclk  = sclk_q;
  assign link.sel_n = sel_n_q;
  assign link.sdata = shift_q[`WORD_BITS-1];

  // ==========================================================
  // half-period divider
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) div_q <= 4'h0;
    else if (state_q == HOST_IDLE || tick) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end

  // ==========================================================
  // transfer sequencer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= HOST_IDLE;
      shift_q   <= 16'h0000;
      bits_q    <= 5'h00;
      sclk_q    <= 1'b0;
      sel_n_q   <= 1'b1;
      req_ready <= 1'b1;
    end else begin
      case (state_q)
        HOST_IDLE: begin
          if (req_valid && req_ready) begin
            shift_q   <= {req_addr, req_data};
            sel_n_q   <= 1'b0;
            bits_q    <= 5'h00;
            req_ready <= 1'b0;
            state_q   <= HOST_LOW;
          end
        end
        HOST_LOW: if (tick) begin
          sclk_q  <= 1'b1;
          state_q <= HOST_HIGH;
        end
        HOST_HIGH: if (tick) begin
          sclk_q <= 1'b0;
          bits_q <= bits_q + 5'h01;
          if (bits_q == 5'(`WORD_BITS - 1)) state_q <= HOST_DONE;
          else begin
            shift_q <= {shift_q[`WORD_BITS-2:0], 1'b0};
            state_q <= HOST_LOW;
          end
        end
        HOST_DONE: if (tick) begin
          sel_n_q   <= 1'b1;
          req_ready <= 1'b1;
          state_q   <= HOST_IDLE;
        end
        default: state_q <= HOST_IDLE;
      endcase
    end
  end
endmodule // led_mux_host
`default_nettype wire

// ==== verilog/led_mux_device.sv ====
/*
 * Driver end: serial receiver, display store and multiplex scan onto
 * nine shared drive pins. Assumes one 20 MHz clock; serial pins and the
 * multiplex clock are asynchronous and sampled here.
 */
`timescale 1ns/100ps
`default_nettype none
module led_mux_device
  import led_mux_pkg::*;
#(
  parameter int DIGIT_DRIVERS = 8
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  led_mux_if.device               link,
  input  wire logic               mux_clock_in,
  output var  led_mux_pkg::pins_t drive_out,
  output var  led_mux_pkg::pins_t drive_oe,
  output var  led_mux_pkg::word_t word_out,
  output var  logic               word_strobe
);
  import led_mux_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [1:0] sclk_s, sel_s, sdat_s, mux_s;
  logic       sclk_d1, sel_d1, mux_d1;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s <= 2'b00; sel_s <= 2'b11; sdat_s <= 2'b00; mux_s <= 2'b00;
      sclk_d1 <= 1'b0; sel_d1 <= 1'b1; mux_d1 <= 1'b0;
    end else begin
      sclk_s  <= {sclk_s[0], link.sclk};
      sel_s   <= {sel_s[0], link.sel_n};
      sdat_s  <= {sdat_s[0], link.sdata};
      mux_s   <= {mux_s[0], mux_clock_in};
      sclk_d1 <= sclk_s[1];
      sel_d1  <= sel_s[1];
      mux_d1  <= mux_s[1];
    end
  end

  // only edges seen while selected count, so idle level never matters
  logic sclk_rise, sel_rise, mux_rise;
  assign sclk_rise = sclk_s[1] & ~sclk_d1 & ~sel_s[1];
  assign sel_rise  = sel_s[1] & ~sel_d1;
  assign mux_rise  = mux_s[1] & ~mux_d1;

  // ==========================================================
  // receiver; no output path back to the host exists
  word_t shift_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) shift_q <= 16'h0000;
    else if (sclk_rise) shift_q <= {shift_q[`WORD_BITS-2:0], sdat_s[1]};
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      word_out    <= 16'h0000;
      word_strobe <= 1'b0;
    end else begin
      word_strobe <= sel_rise;
      if (sel_rise) word_out <= shift_q;
    end
  end

  // ==========================================================
  // command execution: digit bytes and scan limit
  byte_t      digit_q [`NUM_DIGITS];
  logic [2:0] limit_q;
  byte_t      cmd_addr, cmd_data;
  assign cmd_addr = shift_q[`ADDR_MSB:`ADDR_LSB];
  assign cmd_data = shift_q[`DATA_MSB:`DATA_LSB];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      limit_q <= `SCAN_LIMIT_RST;
      for (int i = 0; i < `NUM_DIGITS; i++) digit_q[i] <= 8'h00;
    end else if (sel_rise) begin
      if (cmd_addr == `SCAN_LIMIT_ADDR) limit_q <= cmd_data[2:0];
      // one display plane only, so all three digit address groups land here
      if ((cmd_addr & `DIGIT_ADDR_MASK) == `DIGIT_ADDR_P0 ||
          (cmd_addr & `DIGIT_ADDR_MASK) == `DIGIT_ADDR_P1 ||
          (cmd_addr & `DIGIT_ADDR_MASK) == `DIGIT_ADDR_BASE)
        digit_q[cmd_addr[2:0]] <= cmd_data;
    end
  end

  // ==========================================================
  // scan timing: equal slots from multiplex clock edges
  logic [15:0] slot_q;
  logic [2:0]  digit_sel_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slot_q      <= 16'h0000;
      digit_sel_q <= 3'h0;
    end else if (mux_rise) begin
      if (slot_q == `SLOT_MUX_TICKS - 16'h0001) begin
        slot_q      <= 16'h0000;
        digit_sel_q <= (digit_sel_q >= limit_q) ? 3'h0 : digit_sel_q + 3'h1;
      end else slot_q <= slot_q + 16'h0001;
    end
  end

  // ==========================================================
  // pin mapping: pin k sinks, others carry dp,g,f,e,d,c,b; pin 8 is a
  function automatic pins_t seg_map(input logic [2:0] k, input byte_t seg);
    pins_t p;
    int    j;
    p = '0;
    j = 0;
    // seg bit order: 7=dp 6=a 5=b 4=c 3=d 2=e 1=f 0=g
    for (int pin = 0; pin < `NUM_DIGITS; pin++) begin
      if (pin != int'(k)) begin
        case (j)
          0: p[pin] = seg[7];
          1: p[pin] = seg[0];
          2: p[pin] = seg[1];
          3: p[pin] = seg[2];
          4: p[pin] = seg[3];
          5: p[pin] = seg[4];
          default: p[pin] = seg[5];
        endcase
        j++;
      end
    end
    p[`DRIVE_PINS-1] = seg[6];
    return p;
  endfunction

  pins_t lit;
  logic  have_driver;
  assign lit = seg_map(digit_sel_q, digit_q[digit_sel_q]);
  assign have_driver = (int'(digit_sel_q) < DIGIT_DRIVERS);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drive_out <= '0;
      drive_oe  <= '0;
    end else begin
      drive_out <= lit; // cathode pin driven low
      // unlit pins released; absent driver means no sink, no light
      drive_oe  <= have_driver ? (lit | (pins_t'(1) << digit_sel_q)) : '0;
    end
  end
endmodule // led_mux_device
`default_nettype wire

// ==== bench/led_mux_chk.sv ====
/* checker for the serial wires between host end and device end.
   assumes host clock and sys_rst, wires taken from the interface. */
`timescale 1ns/100ps
`default_nettype none
module led_mux_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdata
);
  logic [4:0] rises_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========
  // serial clock rises per frame
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) rises_q <= 5'h00;
    else if ($fell(sel_n)) rises_q <= 5'h00;
    else if ($rose(sclk) && !sel_n) rises_q <= rises_q + 5'h01;
  sequence high_half;
    sclk [*4] ##1 !sclk;
  endsequence
  // ==========
  // wire timing
  idle_clock_a: assert property (sel_n |-> !sclk) else $error("sclk moved");
  rise_sel_a: assert property ($rose(sclk) |-> !sel_n) else $error("rise out");
  bit_width_a: assert property ($rose(sclk) |-> high_half) else $error("half bit");
  data_hold_a: assert property ($rose(sclk) |-> $stable(sdata) ##1 $stable(sdata))
    else $error("sdata moved");
  word_len_a: assert property ($rose(sel_n) |-> rises_q == 5'h10) else $error("bits");
  frame_end_a: assert property ($fell(sel_n) |-> ##[128:140] $rose(sel_n))
    else $error("frame len");
  sel_gap_a: assert property ($rose(sel_n) |=> !sclk) else $error("gap");
  start_low_a: assert property ($fell(sel_n) |-> !sclk [*4]) else $error("start");
endmodule // led_mux_chk
`default_nettype wire

// ==== bench/led_mux_serial_front_end_tb_top.sv ====
/* bench top: host end feeds device end, words and drive pins checked.
   assumes package, interface and both ends are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module led_mux_serial_front_end_tb_top;
  import led_mux_pkg::*;
  logic  clock = 0, sys_rst = 1, req_valid = 0, mux_clk = 0, req_ready, word_strobe;
  byte_t req_addr = 8'h00, req_data = 8'h00;
  pins_t drive_out, drive_oe;
  word_t word_out;
  word_t exp_q[$];
  byte_t dig[5];
  int    fails = 0, checks = 0, seed = 20;
  led_mux_if link ();
  led_mux_host led_mux_host_i (.clock(clock), .sys_rst(sys_rst), .link(link),
    .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready));
  led_mux_device #(.DIGIT_DRIVERS(8)) led_mux_device_i (.clock(clock), .sys_rst(sys_rst),
    .link(link), .mux_clock_in(mux_clk), .drive_out(drive_out), .drive_oe(drive_oe),
    .word_out(word_out), .word_strobe(word_strobe));
  led_mux_chk led_mux_chk_i (.clock(clock), .sys_rst(sys_rst), .sclk(link.sclk),
    .sel_n(link.sel_n), .sdata(link.sdata));
  always #25 clock = ~clock;
  // phase offset keeps the scan clock unrelated to clock
  initial begin
    #13;
    forever #200 mux_clk = ~mux_clk;
  end
  // ==========
  // checking
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clock) if (word_strobe === 1'b1) begin
    chk("word", word_out, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
  end
  // ==========
  // stimulus
  task automatic send(input byte_t a, input byte_t d);
    while (req_ready !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    req_valid = 1'b1;
    req_addr = a;
    req_data = d;
    exp_q.push_back({a, d});
    @(posedge clock);
    #1 req_valid = 1'b0;
  endtask
  task automatic scan_chk(input int k, input byte_t b);
    logic [6:0] v;
    pins_t      oe, ou;
    int         p;
    v = {b[5], b[4], b[3], b[2], b[1], b[0], b[7]};
    p = 0;
    for (int j = 0; j < 8; j++) begin
      oe[j] = (j == k) ? 1'b1 : v[p];
      ou[j] = (j == k) ? 1'b0 : v[p];
      if (j != k) p++;
    end
    oe[8] = b[6];
    ou[8] = b[6];
    repeat (12000) if (drive_oe[k] !== 1'b1 || drive_out[k] !== 1'b0) @(negedge clock);
    repeat (2) @(negedge clock);
    chk("pins oe", 16'(drive_oe), 16'(oe));
    chk("pins lit", 16'(drive_out & drive_oe), 16'(ou));
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) send({4'h1, 4'($random(seed))}, 8'($random(seed)));
    send(8'h03, 8'h04);
    for (int k = 0; k < 5; k++) begin
      dig[k] = 8'($random(seed));
      send(8'h60 + 8'(k), dig[k]);
    end
    for (int k = 0; k < 5; k++) scan_chk(k, dig[k]);
    chk("words left", 16'(exp_q.size()), 16'h0000);
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    summarize();
  end
endmodule // led_mux_serial_front_end_tb_top
`default_nettype wire
